// file: hdl/txseq_pkg.sv
/*
  Constants, register map and state encoding of the transmit sequencer.
  Assumes one 50 MHz clock shared by the host register port and the PHY byte stream.
*/
package txseq_pkg;
  localparam logic [5:0]  ADDR_BCN_GO   = 6'h1A;
  localparam logic [5:0]  ADDR_NORM     = 6'h1B;
  localparam logic [5:0]  ADDR_SLOT1    = 6'h1C;
  localparam logic [5:0]  ADDR_SLOT2    = 6'h1D;
  localparam logic [5:0]  ADDR_RESULT   = 6'h24;
  localparam logic [5:0]  ADDR_FLAGS    = 6'h31;
  localparam logic [5:0]  ADDR_MASK     = 6'h32;
  localparam int          BIT_GO        = 0;
  localparam int          BIT_ENC       = 1;
  localparam int          BIT_ACK       = 2;
  localparam int          BIT_INDIRECT  = 3;
  localparam int          SLOT_LSB      = 3;
  localparam int          RETRY_LSB     = 6;
  localparam int          RES_BUSY      = 5;
  localparam int          RES_FNT_LSB   = 3;
  localparam logic [7:0]  MASK_RESET    = 8'hFF;
  localparam logic [7:0]  PREAMBLE_LEN  = 8'h04;
  localparam logic [7:0]  PHR_POS       = 8'h05;
  localparam logic [7:0]  BODY_POS      = 8'h06;
  localparam logic [7:0]  PREAMBLE_BYTE = 8'h00;
  localparam logic [7:0]  SFD_BYTE      = 8'hA7;
  localparam logic [7:0]  PAD_BYTE      = 8'h00;
  localparam logic [6:0]  PAD_MIN_LEN   = 7'h05;
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
  localparam logic [1:0]  MAX_RETRIES   = 2'h3;
  localparam logic [2:0]  MAX_BACKOFFS  = 3'h4;
  localparam int          CLK_MHZ       = 50;
  localparam int          BACKOFF_NS    = 320000;
  localparam int          BACKOFF_CYC   = (BACKOFF_NS * CLK_MHZ + 999) / 1000;
  localparam int          ACK_WAIT_NS   = 864000;
  localparam int          ACK_WAIT_CYC  = (ACK_WAIT_NS * CLK_MHZ) / 1000;
  typedef enum logic [4:0] {
    S_IDLE    = 5'h01,
    S_BACKOFF = 5'h02,
    S_SEND    = 5'h04,
    S_ACKWAIT = 5'h08,
    S_DONE    = 5'h10
  } txseq_state_t;
endpackage : txseq_pkg

// file: hdl/txseq_top.sv
/*
  Transmit sequencer: four frame buffers, trigger and status registers, CSMA-CA,
  slot wait, retries, framing and checksum, and a two-entry output byte buffer.
  Assumes all inputs are on i_clk; the PHY pulls bytes with valid/ready.
*/
`timescale 1ns/100ps
module txseq_top #(
  parameter int BACKOFF_CYC  = txseq_pkg::BACKOFF_CYC,  // backoff period in cycles
  parameter int ACK_WAIT_CYC = txseq_pkg::ACK_WAIT_CYC  // acknowledge wait in cycles
) (
  input  wire logic       i_clk,               // system clock
  input  wire logic       i_rst_n,             // async reset, active low
  input  wire logic       i_reg_we,            // register write strobe
  input  wire logic       i_reg_re,            // register read strobe
  input  wire logic [5:0] i_reg_addr,          // register address
  input  wire logic [7:0] i_reg_wdata,         // register write data
  output logic      [7:0] o_reg_rdata,         // register read data
  output logic            o_irq_n,             // interrupt, active low
  input  wire logic       i_buf_we,            // buffer byte write
  input  wire logic [1:0] i_buf_sel,           // 0 normal,1 slot1,2 slot2,3 beacon
  input  wire logic [6:0] i_buf_addr,          // byte index in buffer
  input  wire logic [7:0] i_buf_wdata,         // buffer byte
  output logic            o_tx_valid,          // output byte valid
  output logic      [7:0] o_tx_data,           // output byte
  input  wire logic       i_tx_ready,          // PHY takes byte
  output logic            o_tx_encrypt,        // frame in flight needs encryption
  input  wire logic       i_cca_clear,         // channel idle
  input  wire logic       i_ack_seen,          // acknowledgement received pulse
  input  wire logic       i_ack_pending,       // its frame pending bit
  input  wire logic       i_coordinator,       // device acts as coordinator
  input  wire logic       i_data_request,      // poll for indirect data seen
  input  wire logic       i_crc_enable,        // append checksum
  input  wire logic       i_beacon_mode,       // beacon-enabled network
  input  wire logic       i_superframe_start,  // superframe start pulse
  input  wire logic       i_cfp_active,        // contention-free period running
  input  wire logic [2:0] i_gts_slot,          // current slot number
  input  wire logic       i_gts_time_ok        // enough time left in slot
);
  localparam logic [15:0] BO_LOAD  = 16'(BACKOFF_CYC - 1);
  localparam logic [15:0] ACK_LOAD = 16'(ACK_WAIT_CYC - 1);

  logic                   rst_q1;
  logic                   rst_n;
  logic [7:0]             mem [0:511];
  txseq_pkg::txseq_state_t st;
  logic [3:0]             pend;
  logic [3:0]             enc;
  logic                   ack_n;
  logic                   indirect;
  logic                   ack_frame_pending_seen;
  logic [2:0]             slot_sel [2];
  logic                   slot_ack [2];
  logic [1:0]             limit [2];
  logic [1:0]             used [2];
  logic [7:0]             result;
  logic [2:0]             flags;
  logic [7:0]             mask;
  logic                   sf_seen;
  logic [1:0]             cur;
  logic [1:0]             retries;
  logic [1:0]             limit_cur;
  logic                   ack_cur;
  logic                   crc_on;
  logic [2:0]             nb;
  logic [15:0]            cnt;
  logic [7:0]             pos;
  logic [15:0]            crc;
  logic                   res_fail;
  logic                   res_busy;
  logic                   res_fnt;
  logic [7:0]             tx_q1;
  logic                   tx_v1;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int k = 0; k < 8; k++) begin
      r = (r[0] ^ d[k]) ? ((r >> 1) ^ txseq_pkg::CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_buf_we) begin
      mem[{i_buf_sel, i_buf_addr}] <= i_buf_wdata;
    end
  end

  // register decode
  wire [3:0] wr_buf  = {i_reg_we && i_reg_addr == txseq_pkg::ADDR_BCN_GO,
                        i_reg_we && i_reg_addr == txseq_pkg::ADDR_SLOT2,
                        i_reg_we && i_reg_addr == txseq_pkg::ADDR_SLOT1,
                        i_reg_we && i_reg_addr == txseq_pkg::ADDR_NORM};
  wire [3:0] go_req  = wr_buf & {4{i_reg_wdata[txseq_pkg::BIT_GO]}};
  wire       rd_flag = i_reg_re && i_reg_addr == txseq_pkg::ADDR_FLAGS;
  wire       wr_mask = i_reg_we && i_reg_addr == txseq_pkg::ADDR_MASK;
  wire       release_now = st == txseq_pkg::S_DONE;

  // launch selection: beacon, then slots, then normal
  wire [1:0] gts_hit;
  wire       bcn_go   = pend[3] && (!i_beacon_mode || sf_seen);
  wire       norm_go  = pend[0] && !i_cfp_active &&
                        (!(indirect && i_coordinator) || i_data_request);
  wire [1:0] nsel     = bcn_go ? 2'h3 : gts_hit[0] ? 2'h1 : gts_hit[1] ? 2'h2 : 2'h0;
  wire       launch   = st == txseq_pkg::S_IDLE && (bcn_go || (|gts_hit) || norm_go);
  wire       n_gts    = nsel[0] ^ nsel[1];
  wire       n_ack    = nsel == 2'h0 ? ack_n : n_gts ? slot_ack[nsel[1]] : 1'b0;
  wire [1:0] n_limit  = nsel == 2'h0 ? txseq_pkg::MAX_RETRIES : limit[nsel[1]];
  wire       cur_gts  = cur[0] ^ cur[1];
  wire       gts_cut  = cur_gts && !i_cfp_active;
  wire       bo_busy  = cnt == 16'h0000 && !i_cca_clear;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_buf
      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          pend[g] <= 1'b0;
          enc[g]  <= 1'b0;
        end else begin
          if (wr_buf[g]) begin
            enc[g] <= i_reg_wdata[txseq_pkg::BIT_ENC];
          end
          if (release_now && cur == 2'(g)) begin
            pend[g] <= 1'b0;
          end else if (go_req[g]) begin
            pend[g] <= 1'b1;
          end
        end
      end
    end
    for (g = 0; g < 2; g++) begin : g_slot
      assign gts_hit[g] = pend[g+1] && i_cfp_active && i_gts_slot == slot_sel[g];
      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          slot_sel[g] <= 3'h0;
          slot_ack[g] <= 1'b0;
          limit[g]    <= 2'h0;
          used[g]     <= 2'h0;
        end else begin
          if (wr_buf[g+1]) begin
            slot_sel[g] <= i_reg_wdata[txseq_pkg::SLOT_LSB +: 3];
            slot_ack[g] <= i_reg_wdata[txseq_pkg::BIT_ACK];
            limit[g]    <= i_reg_wdata[txseq_pkg::RETRY_LSB +: 2];
          end
          if (release_now && cur == 2'(g + 1) && !res_fail && !res_fnt) begin
            used[g] <= retries;
          end
        end
      end
    end
  endgenerate

  // byte generation
  wire [6:0] frame_len = mem[{cur, 7'h01}][6:0];
  wire [6:0] body_len  = frame_len < txseq_pkg::PAD_MIN_LEN ? txseq_pkg::PAD_MIN_LEN
                                                            : frame_len;
  wire [7:0] body_end  = txseq_pkg::BODY_POS + {1'b0, body_len};
  wire [7:0] last_pos  = crc_on ? body_end + 8'h01 : body_end - 8'h01;
  wire [7:0] phr       = {1'b0, body_len} + (crc_on ? 8'h02 : 8'h00);
  wire [7:0] body_idx  = pos - txseq_pkg::BODY_POS;
  wire       in_body   = pos >= txseq_pkg::BODY_POS && pos < body_end;
  wire [6:0] body_addr = body_idx[6:0] + 7'h02;
  wire [7:0] body_byte = body_idx < {1'b0, frame_len} ? mem[{cur, body_addr}]
                                                      : txseq_pkg::PAD_BYTE;
  wire [7:0] push_byte = pos < txseq_pkg::PREAMBLE_LEN ? txseq_pkg::PREAMBLE_BYTE :
                         pos == txseq_pkg::PREAMBLE_LEN ? txseq_pkg::SFD_BYTE :
                         pos == txseq_pkg::PHR_POS ? phr :
                         in_body ? body_byte :
                         pos == body_end ? crc[7:0] : crc[15:8];
  wire       push      = st == txseq_pkg::S_SEND && !tx_v1;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st        <= txseq_pkg::S_IDLE;
      cur       <= 2'h0;
      retries   <= 2'h0;
      limit_cur <= 2'h0;
      ack_cur   <= 1'b0;
      crc_on    <= 1'b0;
      nb        <= 3'h0;
      cnt       <= 16'h0000;
      pos       <= 8'h00;
      crc       <= 16'h0000;
      res_fail  <= 1'b0;
      res_busy  <= 1'b0;
      res_fnt   <= 1'b0;
    end else begin
      unique case (st)
        txseq_pkg::S_IDLE: begin
          pos <= 8'h00;
          crc <= 16'h0000;
          nb  <= 3'h0;
          cnt <= BO_LOAD;
          if (launch) begin
            cur       <= nsel;
            retries   <= 2'h0;
            limit_cur <= n_limit;
            ack_cur   <= n_ack;
            crc_on    <= i_crc_enable;
            res_fail  <= 1'b0;
            res_busy  <= 1'b0;
            res_fnt   <= n_gts && !i_gts_time_ok;
            if (n_gts && !i_gts_time_ok) begin
              st <= txseq_pkg::S_DONE;
            end else if (nsel == 2'h0) begin
              st <= txseq_pkg::S_BACKOFF;
            end else begin
              st <= txseq_pkg::S_SEND;
            end
          end
        end
        txseq_pkg::S_BACKOFF: begin
          if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
          end else if (i_cca_clear) begin
            st  <= txseq_pkg::S_SEND;
            pos <= 8'h00;
            crc <= 16'h0000;
          end else if (nb == txseq_pkg::MAX_BACKOFFS) begin
            res_busy <= 1'b1;
            res_fail <= 1'b1;
            st       <= txseq_pkg::S_DONE;
          end else begin
            nb  <= nb + 3'h1;
            cnt <= BO_LOAD;
          end
        end
        txseq_pkg::S_SEND: begin
          if (push) begin
            pos <= pos + 8'h01;
            if (in_body) begin
              crc <= crc_step(crc, push_byte);
            end
            if (pos == last_pos) begin
              cnt <= ACK_LOAD;
              st  <= ack_cur ? txseq_pkg::S_ACKWAIT : txseq_pkg::S_DONE;
            end
          end
        end
        txseq_pkg::S_ACKWAIT: begin
          if (i_ack_seen) begin
            st <= txseq_pkg::S_DONE;
          end else if (gts_cut || cnt == 16'h0000) begin
            if (!gts_cut && retries != limit_cur) begin
              retries <= retries + 2'h1;
              pos     <= 8'h00;
              crc     <= 16'h0000;
              nb      <= 3'h0;
              cnt     <= BO_LOAD;
              st      <= cur == 2'h0 ? txseq_pkg::S_BACKOFF : txseq_pkg::S_SEND;
            end else begin
              res_fail <= 1'b1;
              st       <= txseq_pkg::S_DONE;
            end
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        txseq_pkg::S_DONE: begin
          st <= txseq_pkg::S_IDLE;
        end
      endcase
    end
  end

  // status, flags and control registers
  wire [2:0] set_flag = {3{release_now}} & {cur == 2'h2, cur == 2'h1, cur == 2'h0};

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      result  <= 8'h00;
      flags   <= 3'h0;
      mask    <= txseq_pkg::MASK_RESET;
      ack_n   <= 1'b0;
      indirect <= 1'b0;
      ack_frame_pending_seen <= 1'b0;
      sf_seen <= 1'b0;
    end else begin
      flags <= (flags & ~{3{rd_flag}}) | set_flag;
      if (wr_mask) begin
        mask <= i_reg_wdata;
      end
      if (wr_buf[0]) begin
        ack_n    <= i_reg_wdata[txseq_pkg::BIT_ACK];
        indirect <= i_reg_wdata[txseq_pkg::BIT_INDIRECT];
      end
      if (st == txseq_pkg::S_ACKWAIT && i_ack_seen && cur == 2'h0) begin
        ack_frame_pending_seen <= i_ack_pending;
      end
      if (i_superframe_start) begin
        sf_seen <= 1'b1;
      end else if (launch && nsel == 2'h3) begin
        sf_seen <= 1'b0;
      end
      if (release_now && cur == 2'h0) begin
        result[0]                       <= res_fail;
        result[txseq_pkg::RETRY_LSB +: 2] <= retries;
        result[txseq_pkg::RES_BUSY]     <= res_busy;
      end
      if (release_now && cur_gts) begin
        result[cur]                            <= res_fail && !res_fnt;
        result[txseq_pkg::RES_FNT_LSB - 1 + cur] <= res_fnt;
      end
    end
  end

  // output byte buffer: entry 0 faces the PHY
  wire pop = o_tx_valid && i_tx_ready;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_tx_valid <= 1'b0;
      o_tx_data  <= 8'h00;
      tx_v1      <= 1'b0;
      tx_q1      <= 8'h00;
    end else if (push && (!o_tx_valid || pop)) begin
      o_tx_data  <= (pop && tx_v1) ? tx_q1 : push_byte;
      o_tx_valid <= 1'b1;
    end else if (push) begin
      tx_q1 <= push_byte;
      tx_v1 <= 1'b1;
    end else if (pop) begin
      o_tx_data  <= tx_q1;
      o_tx_valid <= tx_v1;
      tx_v1      <= 1'b0;
    end
  end

  wire [7:0] rd_mux =
    i_reg_addr == txseq_pkg::ADDR_NORM   ? {3'h0, ack_frame_pending_seen, indirect, ack_n, enc[0], 1'b0} :
    i_reg_addr == txseq_pkg::ADDR_SLOT1  ? {used[0], slot_sel[0], slot_ack[0], enc[1], 1'b0} :
    i_reg_addr == txseq_pkg::ADDR_SLOT2  ? {used[1], slot_sel[1], slot_ack[1], enc[2], 1'b0} :
    i_reg_addr == txseq_pkg::ADDR_BCN_GO ? {6'h00, enc[3], 1'b0} :
    i_reg_addr == txseq_pkg::ADDR_RESULT ? result :
    i_reg_addr == txseq_pkg::ADDR_FLAGS  ? {5'h00, flags} :
    i_reg_addr == txseq_pkg::ADDR_MASK   ? mask : 8'h00;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata  <= 8'h00;
      o_irq_n      <= 1'b1;
      o_tx_encrypt <= 1'b0;
    end else begin
      if (i_reg_re) begin
        o_reg_rdata <= rd_mux;
      end
      o_irq_n      <= ~|(flags & ~mask[2:0]);
      o_tx_encrypt <= st != txseq_pkg::S_IDLE && enc[cur];
    end
  end

  property p_go_pends;
    @(posedge i_clk) disable iff (!rst_n)
      (go_req[0] && !release_now) |=> pend[0];
  endproperty
  a_go_pends: assert property (p_go_pends) else $error("go did not pend");

  property p_sfd_out;
    @(posedge i_clk) disable iff (!rst_n)
      (push && pos == txseq_pkg::PREAMBLE_LEN) |=>
        ((o_tx_valid && o_tx_data == txseq_pkg::SFD_BYTE) ||
         (tx_v1 && tx_q1 == txseq_pkg::SFD_BYTE));
  endproperty
  a_sfd_out: assert property (p_sfd_out) else $error("delimiter not sent");

  property p_norm_flag;
    @(posedge i_clk) disable iff (!rst_n)
      (release_now && cur == 2'h0) |=> flags[0];
  endproperty
  a_norm_flag: assert property (p_norm_flag) else $error("normal flag missing");

  property p_beacon_silent;
    @(posedge i_clk) disable iff (!rst_n)
      (release_now && cur == 2'h3) |=> ($stable(result) && !$rose(flags[0]));
  endproperty
  a_beacon_silent: assert property (p_beacon_silent) else $error("beacon left status");

  property p_mask_gates;
    @(posedge i_clk) disable iff (!rst_n)
      (mask[2:0] == 3'h7) [*2] |=> o_irq_n;
  endproperty
  a_mask_gates: assert property (p_mask_gates) else $error("masked flag drove pin");

  property p_set_wins;
    @(posedge i_clk) disable iff (!rst_n)
      (rd_flag && set_flag[1]) |=> flags[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag set lost on read");

  property p_busy_abort;
    @(posedge i_clk) disable iff (!rst_n)
      (st == txseq_pkg::S_BACKOFF && bo_busy && nb == 3'h4) |=> ##1 result[5];
  endproperty
  a_busy_abort: assert property (p_busy_abort) else $error("busy abort not shown");

  property p_slot_wait;
    @(posedge i_clk) disable iff (!rst_n)
      (st == txseq_pkg::S_IDLE && !i_cfp_active && !bcn_go && !norm_go)
        |=> st == txseq_pkg::S_IDLE;
  endproperty
  a_slot_wait: assert property (p_slot_wait) else $error("slot frame sent early");

  property p_retry_report;
    @(posedge i_clk) disable iff (!rst_n)
      (release_now && cur == 2'h0) |=> result[7:6] == $past(retries);
  endproperty
  a_retry_report: assert property (p_retry_report) else $error("retry count wrong");
endmodule : txseq_top

// file: dv/txseq_host.sv
/*
  Host model: writes frame buffers and reads or writes sequencer registers.
  Assumes the sequencer samples on the rising edge; inputs move on falling edges.
*/
`timescale 1ns/100ps
module txseq_host (
  input  wire logic       i_clk,    // system clock
  input  wire logic [7:0] i_rdata,  // register read data
  output logic            o_we,     // register write
  output logic            o_re,     // register read
  output logic      [5:0] o_addr,   // register address
  output logic      [7:0] o_wdata,  // register data
  output logic            o_bwe,    // buffer write
  output logic      [1:0] o_bsel,   // buffer select
  output logic      [6:0] o_baddr,  // buffer index
  output logic      [7:0] o_bdata   // buffer byte
);
  initial begin
    {o_we, o_re, o_bwe} = 3'h0;
    {o_addr, o_wdata, o_bsel, o_baddr, o_bdata} = 31'h0;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr  = a;
    o_wdata = d;
    o_we    = 1'b1;
    @(negedge i_clk);
    o_we    = 1'b0;
  endtask : wr
  // read data lands at the strobe's edge, so it is settled at the next fall
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_re   = 1'b1;
    @(negedge i_clk);
    o_re   = 1'b0;
    d      = i_rdata;
  endtask : rd
  // header length 2, then frame length n, then bytes 01, 02, ...
  task automatic fill(input logic [1:0] s, input logic [6:0] n);
    for (int i = 0; i < n + 2; i++) begin
      @(negedge i_clk);
      o_bsel  = s;
      o_baddr = 7'(i);
      o_bdata = (i == 0) ? 8'h02 : (i == 1) ? {1'b0, n} : 8'(i - 1);
      o_bwe   = 1'b1;
    end
    @(negedge i_clk);
    o_bwe = 1'b0;
  endtask : fill
endmodule : txseq_host

// file: dv/tb.sv
/*
  Testbench of the transmit sequencer: host register calls with expected values.
  Assumes shortened backoff and acknowledge waits; the PHY sink stalls one cycle in three.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  logic       clk, we, re, bwe, tx_valid, tx_enc, irq_n;
  logic       rst_n = 1'b0, tx_ready = 1'b0, ack = 1'b0, ack_en = 1'b0;
  logic       cca = 1'b1, cfp = 1'b0, time_ok = 1'b1, crc_en = 1'b1;
  logic       bmode = 1'b0, sf = 1'b0;
  logic [2:0] slot = 3'h0;
  logic [1:0] bsel;
  logic [5:0] addr;
  logic [6:0] baddr;
  logic [7:0] wdata, bdata, rdata, tx_data, d;
  logic [7:0] q[$];
  logic [7:0] exp_a [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hA7, 8'h07,
                             8'h01, 8'h02, 8'h03, 8'h00, 8'h00};
  int         miscompares = 0, check_count = 0, idle = 0, cyc = 0, enc_cyc = 0;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // acknowledge comes a few idle cycles after each frame while enabled
  always @(negedge clk) begin
    cyc      <= cyc + 1;
    tx_ready <= (cyc % 3) != 0;
    idle     <= tx_valid ? 0 : idle + 1;
    ack      <= ack_en && (idle == 6);
    enc_cyc  <= enc_cyc + int'(tx_enc);
  end
  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      q.push_back(tx_data);
    end
  end
  txseq_host host (.i_clk(clk), .i_rdata(rdata), .o_we(we), .o_re(re), .o_addr(addr),
    .o_wdata(wdata), .o_bwe(bwe), .o_bsel(bsel), .o_baddr(baddr), .o_bdata(bdata));
  txseq_top #(.BACKOFF_CYC(8), .ACK_WAIT_CYC(40)) dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_reg_we(we), .i_reg_re(re), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_irq_n(irq_n), .i_buf_we(bwe),
    .i_buf_sel(bsel), .i_buf_addr(baddr), .i_buf_wdata(bdata), .o_tx_valid(tx_valid),
    .o_tx_data(tx_data), .i_tx_ready(tx_ready), .o_tx_encrypt(tx_enc), .i_cca_clear(cca),
    .i_ack_seen(ack), .i_ack_pending(ack_en), .i_coordinator(1'b0),
    .i_data_request(1'b0), .i_crc_enable(crc_en), .i_beacon_mode(bmode),
    .i_superframe_start(sf), .i_cfp_active(cfp), .i_gts_slot(slot),
    .i_gts_time_ok(time_ok));
  task automatic final_report;
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  // flags clear on read, so polling only ever sees each completion once
  task automatic wait_flag(input int b);
    logic [7:0] f;
    f = 8'h00;
    for (int i = 0; i < 400 && f[b] !== 1'b1; i++) host.rd(txseq_pkg::ADDR_FLAGS, f);
    `CHK(f[b], 1'b1)
  endtask : wait_flag
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report();
  end
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    host.rd(txseq_pkg::ADDR_MASK, d);
    `CHK(d, 8'hFF)
    host.rd(txseq_pkg::ADDR_RESULT, d);
    `CHK(d, 8'h00)
    host.wr(txseq_pkg::ADDR_MASK, 8'hFE);
    host.fill(2'h0, 7'h03);
    host.wr(txseq_pkg::ADDR_NORM, 8'h01);
    host.rd(txseq_pkg::ADDR_NORM, d);
    `CHK(d[0], 1'b0)
    for (int i = 0; i < 500 && irq_n !== 1'b0; i++) @(negedge clk);
    `CHK(irq_n, 1'b0)
    // up to two bytes may still sit in the output buffer when the flag rises
    repeat (4) @(negedge clk);
    `CHK(enc_cyc, 0)
    `CHK(q.size(), 13)
    foreach (exp_a[i]) `CHK(q[i], exp_a[i])
    host.rd(txseq_pkg::ADDR_FLAGS, d);
    `CHK(d, 8'h01)
    repeat (2) @(negedge clk);
    `CHK(irq_n, 1'b1)
    host.rd(txseq_pkg::ADDR_RESULT, d);
    `CHK(d, 8'h00)
    ack_en = 1'b1;
    host.wr(txseq_pkg::ADDR_NORM, 8'h05);
    wait_flag(0);
    host.rd(txseq_pkg::ADDR_RESULT, d);
    `CHK(d, 8'h00)
    host.rd(txseq_pkg::ADDR_NORM, d);
    `CHK(d, 8'h14)
    ack_en = 1'b0;
    host.wr(txseq_pkg::ADDR_NORM, 8'h05);
    wait_flag(0);
    host.rd(txseq_pkg::ADDR_RESULT, d);
    `CHK(d, 8'hC1)
    cca = 1'b0;
    host.wr(txseq_pkg::ADDR_NORM, 8'h01);
    wait_flag(0);
    host.rd(txseq_pkg::ADDR_RESULT, d);
    `CHK(d[5:0], 6'h21)
    cca = 1'b1;
    cfp = 1'b1;
    host.fill(2'h1, 7'h03);
    q.delete();
    host.wr(txseq_pkg::ADDR_SLOT1, 8'h93);
    repeat (40) @(negedge clk);
    `CHK(q.size(), 0)
    host.rd(txseq_pkg::ADDR_SLOT1, d);
    `CHK(d, 8'h12)
    slot = 3'h2;
    wait_flag(1);
    repeat (4) @(negedge clk);
    `CHK(q.size(), 13)
    `CHK(enc_cyc > 0, 1'b1)
    host.rd(txseq_pkg::ADDR_RESULT, d);
    `CHK(d[4:1], 4'h0)
    time_ok = 1'b0;
    host.wr(txseq_pkg::ADDR_SLOT2, 8'h11);
    wait_flag(2);
    host.rd(txseq_pkg::ADDR_RESULT, d);
    `CHK(d[4:2], 3'b100)
    bmode  = 1'b1;
    crc_en = 1'b0;
    host.fill(2'h3, 7'h03);
    q.delete();
    host.wr(txseq_pkg::ADDR_BCN_GO, 8'h01);
    repeat (40) @(negedge clk);
    `CHK(q.size(), 0)
    sf = 1'b1;
    @(negedge clk);
    sf = 1'b0;
    repeat (60) @(negedge clk);
    `CHK(q.size(), 11)
    `CHK(q[5], 8'h05)
    host.rd(txseq_pkg::ADDR_FLAGS, d);
    `CHK(d, 8'h00)
    host.rd(txseq_pkg::ADDR_RESULT, d);
    `CHK(d, 8'h31)
    final_report();
  end
endmodule : tb
